// *** rtl/mrdc_ctrl.sv ***
// Dynamic-model control and status for the monitoring receiver
// Functional notes
// - Model setting takes codes 0..8; 0 portable is the reset default.
// - Airborne codes 5..7 select Doppler tracking, others carrier phase.
// - Auto: stationary to 2 kn, pedestrian above 2/below 1, auto 10/8.
// - Auto to air-1g needs >60 kn and >400 ft/min; falls back <50 kn.
// - Auto: above 100 kn enter air-1g regardless of climb.
// - Auto: air-2g above 150/below 130, air-4g above 240/below 210.
// - Setting reads 0..8; applied state reads 0..7.
// - New setting applies at once and is sent to non-volatile storage.
// - Jamming level reported as unsigned 0..255.
// - Restart command resets receiver; lock begins about one minute later.
// - Pulse timing error from receiver pulse edge versus simulator time.
// - Position error and separate altitude error reported in meters.
module mrdc_ctrl #(
   parameter int RESTART_CYCLES = mrdc_pkg::RESTART_CYCLES,
   parameter int ERR_W = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [15:0] speed_knots,
   input wire logic [15:0] climb_fpm,
   input wire logic [7:0] interference_level_in,
   input wire logic one_pulse_per_second,
   input wire logic [ERR_W-1:0] sim_time_err_in,
   input wire logic [ERR_W-1:0] pos_err_in,
   input wire logic [ERR_W-1:0] alt_err_in,
   output logic [3:0] rx_model,
   output logic rx_doppler_track,
   output logic rx_reset,
   output logic nv_store,
   output logic [3:0] nv_data,
   output logic irq
);
   // Refuse settings the counters and read mux cannot hold
   if (RESTART_CYCLES < 1 || ERR_W < 1 || ERR_W > 32) begin : g_bad_param
      $error("mrdc_ctrl: bad parameter");
   end

   logic [3:0] dynamic_model_select;
   logic [3:0] applied_model_state;
   logic [15:0] spd;
   logic [15:0] clm;
   logic [31:0] restart_cnt;
   logic [7:0] jam;
   logic [ERR_W-1:0] pps_err;
   logic [ERR_W-1:0] pos_err;
   logic [ERR_W-1:0] alt_err;
   logic pps_prev;
   logic [mrdc_pkg::IRQ_WIDTH-1:0] irq_status;
   logic [mrdc_pkg::IRQ_WIDTH-1:0] irq_enable;

   // Airborne test shared by tracking output and checks
   function automatic logic mrdc_is_air(input logic [3:0] m);
      return m >= mrdc_pkg::MODEL_AIR1G && m <= mrdc_pkg::MODEL_AIR4G;
   endfunction : mrdc_is_air

   // Register decode
   wire wr_sel = reg_wr && reg_addr == mrdc_pkg::ADDR_MODEL_SELECT;
   wire wr_ok = wr_sel && reg_wdata <= 32'h0000_0008;
   wire wr_spd = reg_wr && reg_addr == mrdc_pkg::ADDR_SPEED;
   wire wr_clm = reg_wr && reg_addr == mrdc_pkg::ADDR_CLIMB;
   wire wr_rst = reg_wr && reg_addr == mrdc_pkg::ADDR_RESTART
      && reg_wdata[0];
   wire wr_ien = reg_wr && reg_addr == mrdc_pkg::ADDR_IRQ_ENABLE;
   wire wr_clr = reg_wr && reg_addr == mrdc_pkg::ADDR_IRQ_CLEAR;
   wire restart_busy = restart_cnt != 32'h0;
   wire restart_done = restart_cnt == 32'h1;
   wire pps_rise = one_pulse_per_second && !pps_prev;

   // Automatic model choice with hysteresis, sea never chosen
   wire climb_ok = clm > mrdc_pkg::FPM_CLIMB;
   wire up_air1 = (spd > mrdc_pkg::KN_AIR1_UP && climb_ok)
      || spd > mrdc_pkg::KN_AIR1_FAST;
   logic [3:0] auto_model;
   always_comb begin
      auto_model = applied_model_state;
      case (applied_model_state)
         mrdc_pkg::MODEL_PEDESTRIAN: begin
            if (spd > mrdc_pkg::KN_AUTO_UP) begin
               auto_model = mrdc_pkg::MODEL_AUTOMOTIVE;
            end else if (spd < mrdc_pkg::KN_PED_DN) begin
               auto_model = mrdc_pkg::MODEL_STATIONARY;
            end
         end
         mrdc_pkg::MODEL_AUTOMOTIVE: begin
            if (up_air1) begin
               auto_model = mrdc_pkg::MODEL_AIR1G;
            end else if (spd < mrdc_pkg::KN_AUTO_DN) begin
               auto_model = mrdc_pkg::MODEL_PEDESTRIAN;
            end
         end
         mrdc_pkg::MODEL_AIR1G: begin
            if (spd > mrdc_pkg::KN_AIR2_UP) begin
               auto_model = mrdc_pkg::MODEL_AIR2G;
            end else if (spd < mrdc_pkg::KN_AIR1_DN) begin
               auto_model = mrdc_pkg::MODEL_AUTOMOTIVE;
            end
         end
         mrdc_pkg::MODEL_AIR2G: begin
            if (spd > mrdc_pkg::KN_AIR4_UP) begin
               auto_model = mrdc_pkg::MODEL_AIR4G;
            end else if (spd < mrdc_pkg::KN_AIR2_DN) begin
               auto_model = mrdc_pkg::MODEL_AIR1G;
            end
         end
         mrdc_pkg::MODEL_AIR4G: begin
            if (spd < mrdc_pkg::KN_AIR4_DN) begin
               auto_model = mrdc_pkg::MODEL_AIR2G;
            end
         end
         mrdc_pkg::MODEL_STATIONARY: begin
            if (spd > mrdc_pkg::KN_PED_UP) begin
               auto_model = mrdc_pkg::MODEL_PEDESTRIAN;
            end
         end
         default: begin
            auto_model = mrdc_pkg::MODEL_STATIONARY; // Entry from manual
         end
      endcase
   end

   wire auto_on = dynamic_model_select == mrdc_pkg::MODEL_AUTO;
   wire [3:0] next_applied = auto_on ? auto_model : dynamic_model_select;

   // Event sources for the sticky status
   wire [mrdc_pkg::IRQ_WIDTH-1:0] irq_evt = {restart_done,
      next_applied != applied_model_state};

   // Read data mux
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         mrdc_pkg::ADDR_MODEL_SELECT: rd_mux = {28'h0, dynamic_model_select};
         mrdc_pkg::ADDR_APPLIED_STATE: rd_mux = {28'h0, applied_model_state};
         mrdc_pkg::ADDR_SPEED: rd_mux = {16'h0, spd};
         mrdc_pkg::ADDR_CLIMB: rd_mux = {16'h0, clm};
         mrdc_pkg::ADDR_RESTART: rd_mux = {31'h0, restart_busy};
         mrdc_pkg::ADDR_JAM: rd_mux = {24'h0, jam};
         mrdc_pkg::ADDR_PPS_ERR: rd_mux = 32'(pps_err);
         mrdc_pkg::ADDR_POS_ERR: rd_mux = 32'(pos_err);
         mrdc_pkg::ADDR_ALT_ERR: rd_mux = 32'(alt_err);
         mrdc_pkg::ADDR_IRQ_STATUS: rd_mux = 32'(irq_status);
         mrdc_pkg::ADDR_IRQ_ENABLE: rd_mux = 32'(irq_enable);
         default: rd_mux = 32'h0;
      endcase
   end

   // Bus registers and settings
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dynamic_model_select <= mrdc_pkg::MODEL_RESET;
         spd <= 16'h0;
         clm <= 16'h0;
         irq_enable <= '0;
         reg_rdata <= 32'h0;
      end else begin
         if (wr_ok) begin
            dynamic_model_select <= reg_wdata[3:0];
         end
         if (wr_spd) begin
            spd <= reg_wdata[15:0];
         end
         if (wr_clm) begin
            clm <= reg_wdata[15:0];
         end
         if (wr_ien) begin
            irq_enable <= reg_wdata[mrdc_pkg::IRQ_WIDTH-1:0];
         end
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
      end
   end

   // Applied model and receiver drive
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         applied_model_state <= mrdc_pkg::MODEL_RESET;
         rx_model <= mrdc_pkg::MODEL_RESET;
         rx_doppler_track <= 1'b0;
         nv_store <= 1'b0;
         nv_data <= mrdc_pkg::MODEL_RESET;
      end else begin
         applied_model_state <= next_applied;
         rx_model <= next_applied;
         rx_doppler_track <= mrdc_is_air(next_applied);
         nv_store <= wr_ok;
         if (wr_ok) begin
            nv_data <= reg_wdata[3:0];
         end
      end
   end

   // Restart hold and status capture
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         restart_cnt <= 32'h0;
         rx_reset <= 1'b0;
         jam <= 8'h0;
         pps_err <= '0;
         pos_err <= '0;
         alt_err <= '0;
         pps_prev <= 1'b0;
      end else begin
         if (wr_rst) begin
            restart_cnt <= 32'(RESTART_CYCLES);
         end else if (restart_busy) begin
            restart_cnt <= restart_cnt - 32'h1;
         end
         rx_reset <= wr_rst;
         jam <= interference_level_in;
         pps_prev <= one_pulse_per_second;
         if (pps_rise) begin
            pps_err <= sim_time_err_in;
         end
         pos_err <= pos_err_in;
         alt_err <= alt_err_in;
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~(wr_clr ?
            reg_wdata[mrdc_pkg::IRQ_WIDTH-1:0] : '0)) | irq_evt;
         irq <= |(((irq_status & ~(wr_clr ?
            reg_wdata[mrdc_pkg::IRQ_WIDTH-1:0] : '0)) | irq_evt)
            & irq_enable);
      end
   end

   // Checks
   AST_SEL_RANGE: assert property (@(posedge mclk) disable iff (rst)
      dynamic_model_select <= mrdc_pkg::MODEL_AUTO)
      else $error("model setting out of range");
   AST_DOPPLER: assert property (@(posedge mclk) disable iff (rst)
      rx_doppler_track == mrdc_is_air(rx_model))
      else $error("tracking mode mismatch");
   AST_STAT_UP: assert property (@(posedge mclk) disable iff (rst)
      auto_on && applied_model_state == mrdc_pkg::MODEL_STATIONARY
      && spd > mrdc_pkg::KN_PED_UP && !wr_sel |=>
      applied_model_state == mrdc_pkg::MODEL_PEDESTRIAN)
      else $error("no step to pedestrian");
   AST_AIR1_NEEDS: assert property (@(posedge mclk) disable iff (rst)
      auto_on && applied_model_state == mrdc_pkg::MODEL_AUTOMOTIVE
      && !up_air1 && !wr_sel |=>
      applied_model_state != mrdc_pkg::MODEL_AIR1G)
      else $error("air-1g without cause");
   AST_AIR1_FAST: assert property (@(posedge mclk) disable iff (rst)
      auto_on && applied_model_state == mrdc_pkg::MODEL_AUTOMOTIVE
      && spd > mrdc_pkg::KN_AIR1_FAST && !wr_sel |=>
      applied_model_state == mrdc_pkg::MODEL_AIR1G)
      else $error("fast speed did not enter air-1g");
   AST_AIR4_DN: assert property (@(posedge mclk) disable iff (rst)
      auto_on && applied_model_state == mrdc_pkg::MODEL_AIR4G
      && spd < mrdc_pkg::KN_AIR4_DN && !wr_sel |=>
      applied_model_state == mrdc_pkg::MODEL_AIR2G)
      else $error("no fall back from air-4g");
   AST_APPLIED: assert property (@(posedge mclk) disable iff (rst)
      !auto_on |=> $past(wr_sel) ||
      applied_model_state == $past(dynamic_model_select))
      else $error("applied differs in manual mode");
   AST_NV: assert property (@(posedge mclk) disable iff (rst)
      wr_ok |=> nv_store && nv_data == dynamic_model_select
      ##1 ($past(auto_on) || rx_model == $past(nv_data)))
      else $error("setting not stored or applied");
   AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
      wr_rst |=> rx_reset && restart_busy)
      else $error("restart not issued");
   AST_NO_SEA: assert property (@(posedge mclk) disable iff (rst)
      auto_on |=> applied_model_state != mrdc_pkg::MODEL_SEA)
      else $error("sea applied in auto mode");
   COV_AUTO_AIR: cover property (@(posedge mclk) disable iff (rst)
      auto_on && applied_model_state == mrdc_pkg::MODEL_AIR4G);
   COV_RESTART: cover property (@(posedge mclk) disable iff (rst)
      restart_done);
   COV_IRQ: cover property (@(posedge mclk) disable iff (rst) irq);
endmodule : mrdc_ctrl

// *** rtl/mrdc_pkg.sv ***
// Package of constants for the monitor receiver dynamics controller
package mrdc_pkg;
   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] ADDR_MODEL_SELECT = 8'h00;
   localparam logic [7:0] ADDR_APPLIED_STATE = 8'h04;
   localparam logic [7:0] ADDR_SPEED = 8'h08;
   localparam logic [7:0] ADDR_CLIMB = 8'h0c;
   localparam logic [7:0] ADDR_RESTART = 8'h10;
   localparam logic [7:0] ADDR_JAM = 8'h14;
   localparam logic [7:0] ADDR_PPS_ERR = 8'h18;
   localparam logic [7:0] ADDR_POS_ERR = 8'h1c;
   localparam logic [7:0] ADDR_ALT_ERR = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h2c;
   // Model codes
   localparam logic [3:0] MODEL_PORTABLE = 4'h0;
   localparam logic [3:0] MODEL_STATIONARY = 4'h1;
   localparam logic [3:0] MODEL_PEDESTRIAN = 4'h2;
   localparam logic [3:0] MODEL_AUTOMOTIVE = 4'h3;
   localparam logic [3:0] MODEL_SEA = 4'h4;
   localparam logic [3:0] MODEL_AIR1G = 4'h5;
   localparam logic [3:0] MODEL_AIR2G = 4'h6;
   localparam logic [3:0] MODEL_AIR4G = 4'h7;
   localparam logic [3:0] MODEL_AUTO = 4'h8;
   localparam logic [3:0] MODEL_RESET = 4'h0;
   // Speed thresholds in knots, climb in feet per minute
   localparam logic [15:0] KN_PED_UP = 16'h0002;
   localparam logic [15:0] KN_PED_DN = 16'h0001;
   localparam logic [15:0] KN_AUTO_UP = 16'h000a;
   localparam logic [15:0] KN_AUTO_DN = 16'h0008;
   localparam logic [15:0] KN_AIR1_UP = 16'h003c;
   localparam logic [15:0] KN_AIR1_FAST = 16'h0064;
   localparam logic [15:0] KN_AIR1_DN = 16'h0032;
   localparam logic [15:0] KN_AIR2_UP = 16'h0096;
   localparam logic [15:0] KN_AIR2_DN = 16'h0082;
   localparam logic [15:0] KN_AIR4_UP = 16'h00f0;
   localparam logic [15:0] KN_AIR4_DN = 16'h00d2;
   localparam logic [15:0] FPM_CLIMB = 16'h0190;
   // Restart settle time and clock
   localparam int RESTART_WAIT_S = 60;
   localparam int CLK_HZ = 20000000;
   localparam int RESTART_CYCLES = RESTART_WAIT_S * CLK_HZ;
   // Interrupt bits
   localparam int IRQ_APPLIED_CHG = 0;
   localparam int IRQ_RESTART_DONE = 1;
   localparam int IRQ_WIDTH = 2;
endpackage : mrdc_pkg

// *** sim/mrdc_rx_model.sv ***
// Behavioural model of the embedded monitoring receiver
module mrdc_rx_model #(
   parameter logic [7:0] JAM = 8'hff,
   parameter logic [31:0] PPS_ERR = 32'h0000_0123,
   parameter logic [31:0] POS_ERR = 32'h0000_0456,
   parameter logic [31:0] ALT_ERR = 32'h0000_0789
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic rx_reset,
   output logic [7:0] jam_level,
   output logic pulse,
   output logic [31:0] pps_err,
   output logic [31:0] pos_err,
   output logic [31:0] alt_err
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] cnt;
   logic [7:0] quiet;
   // Fixed measurement values that the bench expects back
   assign jam_level = JAM;
   assign pps_err = PPS_ERR;
   assign pos_err = POS_ERR;
   assign alt_err = ALT_ERR;
   // Pulse every 16 cycles, silent while relocking after a restart
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 6'h0;
         quiet <= 8'h0;
      end else if (rx_reset) begin
         cnt <= 6'h0;
         quiet <= 8'h28; // Gain settling before lock
      end else if (quiet != 8'h0) begin
         quiet <= quiet - 8'h1;
      end else begin
         cnt <= cnt + 6'h1;
      end
   end
   assign pulse = (quiet == 8'h0) && cnt[3];
endmodule : mrdc_rx_model

// *** sim/monitor_receiver_dynamics_ctrl_test.sv ***
// Self-checking bench for the dynamics controller
module monitor_receiver_dynamics_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, pps_err, pos_err, alt_err;
   logic [7:0] jam;
   logic pps, rx_doppler_track, rx_reset, nv_store, irq, seen_nv, seen_rst;
   logic [3:0] rx_model, nv_data, seen_nvd;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   // Auto-mode steps: speed, climb, expected applied model
   logic [15:0] spd [0:18] = '{16'h2, 16'h3, 16'h1, 16'h0, 16'hb, 16'h8,
      16'h7, 16'h3d, 16'h3d, 16'h3d, 16'h32, 16'h31, 16'h65, 16'h97,
      16'h82, 16'h81, 16'hf1, 16'hd2, 16'hd1};
   logic [15:0] fpm [0:18] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h190, 16'h191, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h0, 16'h0};
   logic [3:0] am [0:18] = '{4'h1, 4'h2, 4'h2, 4'h1, 4'h3, 4'h3, 4'h2,
      4'h3, 4'h3, 4'h5, 4'h5, 4'h3, 4'h5, 4'h6, 4'h6, 4'h5, 4'h7, 4'h7,
      4'h6};

   always #25 mclk = ~mclk;

   mrdc_ctrl #(.RESTART_CYCLES(20), .ERR_W(32)) u_dut (.mclk(mclk),
      .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .speed_knots(16'h0), .climb_fpm(16'h0), .interference_level_in(jam),
      .one_pulse_per_second(pps), .sim_time_err_in(pps_err),
      .pos_err_in(pos_err), .alt_err_in(alt_err), .rx_model(rx_model),
      .rx_doppler_track(rx_doppler_track), .rx_reset(rx_reset),
      .nv_store(nv_store), .nv_data(nv_data), .irq(irq));

   mrdc_rx_model u_rx (.mclk(mclk), .rst(rst), .rx_reset(rx_reset),
      .jam_level(jam), .pulse(pps), .pps_err(pps_err),
      .pos_err(pos_err), .alt_err(alt_err));

   // Compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One-cycle register write, then note the pulses it caused
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
      seen_nv = nv_store;
      seen_nvd = nv_data;
      seen_rst = rx_reset;
   endtask : wr

   // One-cycle read, data compared in the following cycle
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : rchk

   task idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : idle

   task end_of_test;
      $display("comparisons %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // Cut a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end

   // Main sequence
   initial begin
      idle(10);
      rst <= 1'b0;
      rchk(mrdc_pkg::ADDR_MODEL_SELECT, 32'h0);
      rchk(mrdc_pkg::ADDR_APPLIED_STATE, 32'h0);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         wr(mrdc_pkg::ADDR_MODEL_SELECT, c);
         check(seen_nv, 32'h1);
         check(seen_nvd, c);
         idle(2);
         check(rx_model, c);
         check(rx_doppler_track, c >= 5);
         rchk(mrdc_pkg::ADDR_MODEL_SELECT, c);
         rchk(mrdc_pkg::ADDR_APPLIED_STATE, c);
      end
      wr(mrdc_pkg::ADDR_MODEL_SELECT, 32'h9);
      check(seen_nv, 32'h0);
      rchk(mrdc_pkg::ADDR_MODEL_SELECT, 32'h7);
      $display("test manual codes done");
      wr(mrdc_pkg::ADDR_SPEED, 32'h0);
      wr(mrdc_pkg::ADDR_CLIMB, 32'h0);
      wr(mrdc_pkg::ADDR_MODEL_SELECT, 32'h8);
      idle(12);
      rchk(mrdc_pkg::ADDR_MODEL_SELECT, 32'h8);
      rchk(mrdc_pkg::ADDR_APPLIED_STATE, 32'h1);
      for (int i = 0; i < 19; i++) begin
         wr(mrdc_pkg::ADDR_SPEED, spd[i]);
         wr(mrdc_pkg::ADDR_CLIMB, fpm[i]);
         idle(12);
         rchk(mrdc_pkg::ADDR_APPLIED_STATE, am[i]);
         check(rx_model, am[i]);
         check(rx_doppler_track, am[i] >= 4'h5);
      end
      $display("test automatic mode done");
      rchk(mrdc_pkg::ADDR_IRQ_STATUS, 32'h1);
      wr(mrdc_pkg::ADDR_IRQ_ENABLE, 32'h2);
      wr(mrdc_pkg::ADDR_IRQ_CLEAR, 32'h3);
      idle(2);
      rchk(mrdc_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(irq, 32'h0);
      wr(mrdc_pkg::ADDR_RESTART, 32'h1);
      check(seen_rst, 32'h1);
      rchk(mrdc_pkg::ADDR_RESTART, 32'h1);
      idle(25);
      rchk(mrdc_pkg::ADDR_RESTART, 32'h0);
      rchk(mrdc_pkg::ADDR_IRQ_STATUS, 32'h2);
      check(irq, 32'h1);
      wr(mrdc_pkg::ADDR_IRQ_ENABLE, 32'h0);
      idle(2);
      check(irq, 32'h0);
      wr(mrdc_pkg::ADDR_IRQ_ENABLE, 32'h2);
      idle(2);
      check(irq, 32'h1);
      wr(mrdc_pkg::ADDR_IRQ_CLEAR, 32'h2);
      idle(2);
      check(irq, 32'h0);
      rchk(mrdc_pkg::ADDR_IRQ_STATUS, 32'h0);
      $display("test restart and interrupt done");
      idle(70);
      rchk(mrdc_pkg::ADDR_JAM, 32'h0000_00ff);
      rchk(mrdc_pkg::ADDR_PPS_ERR, 32'h0000_0123);
      rchk(mrdc_pkg::ADDR_POS_ERR, 32'h0000_0456);
      rchk(mrdc_pkg::ADDR_ALT_ERR, 32'h0000_0789);
      rchk(8'h30, 32'h0);
      $display("test status reads done");
      end_of_test();
   end
endmodule : monitor_receiver_dynamics_ctrl_test
